// File: common/vdtvc_cfg.svh
// register indices, field positions, reset values and timing counts of the slice
`ifndef VDTVC_CFG_SVH
`define VDTVC_CFG_SVH
`define VDTVC_IDX_TRACK_A     8'h39
`define VDTVC_IDX_VBI_B       8'h3A
`define VDTVC_IDX_TRACK_B     8'h3B
`define VDTVC_IDX_GENLOCK     8'h3C
`define VDTVC_IDX_CMD_E       8'h3D
`define VDTVC_RST_TRACK_A     8'h00
`define VDTVC_RST_VBI_B       8'h00
`define VDTVC_RST_TRACK_B     8'h00
`define VDTVC_RST_GENLOCK     8'h00
`define VDTVC_RST_CMD_E       8'h00
`define VDTVC_CHIP_REV        4'h5 // arbitrary revision code
`define VDTVC_BIT_MAC         6
`define VDTVC_BIT_VCR         5
`define VDTVC_BIT_NEWCC       3
`define VDTVC_BIT_OVFL        2
`define VDTVC_VS_PERSIST      3'h4
`define VDTVC_LINE_BLANK_STD  5'h17
`define VDTVC_LINE_BLANK_ALT  5'h06
`define VDTVC_SLICER_RAWCODE  4'h3
`endif

// File: common/vdtvc_pkg.sv
// types shared by the tracking/vbi control slice
package vdtvc_pkg;
    typedef enum logic [1:0] {
        VDTVC_TT_AUTO = 2'h0,
        VDTVC_TT_B    = 2'h1,
        VDTVC_TT_C    = 2'h2,
        VDTVC_TT_D    = 2'h3
    } vdtvc_tt_t;
    typedef enum logic [1:0] {
        VDTVC_VS_FOLLOW = 2'h0,
        VDTVC_VS_COUNT  = 2'h1
    } vdtvc_vs_t;
endpackage

// File: rtl/vdtvc_regs.sv
// register slice of the video decoder: tracking, vbi and genlock controls
`timescale 1ns/10ps
`include "vdtvc_cfg.svh"
// Notes on behaviour
// - burst kill threshold is 11 IRE when clear, 5.5 IRE when set; here held at code 0, 11 IRE
// - chroma converter powers down in chip power-down, and on composite when bit set; here composite never powers it down
// - scaler runs through vertical blanking when clear, stops there when set; here it always runs
// - gain low bit loads into 9-bit gain value only while gain freeze set
// - trap follows manual enable, forced in blanking, or on tape input; here no manual enable bit, only the other two
// - tape threshold codes 0..3 mean 50, 100, 200, 400 PPM
// - tape status reads 1 when burst unlocked to line rate
// - copy protect status reads 1 when protected video detected
// - relax bit drops steady sync level from lock condition
// - chroma and luma clamp disable bits switch off their clamps
// - overrun flag reads 1 when unread caption bytes were overwritten
// - ready flag reads 1 for new unread caption bytes, 0 after read
// - slicer code 3 lines slice widescreen, or raw samples when bit set
// - teletext code 0 auto, codes 1..3 force systems B, C, D
// - bit order clear puts first sliced bit at msb, set at lsb
// - gain time constant fastest at 0, initial tracking 2x faster when set
// - noise filter set: vsync moves only after 4 lines of large error
// - phase priority clear favours late syncs, set favours early syncs
// - headswitch lines: one bit holds frequency, another enables phase tracking
// - 50 Hz blanking ends at line 23, or line 6 when alternate set
// - rising edge of oscillator reset bit resets once and signals stream
// - line id in genlock stream same as pin when clear, inverted when set
module vdtvc_regs
    import vdtvc_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // register port from the serial host bus decoder
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_idx_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // decoder state feeding status and control
    input  wire logic       tape_unlocked_i,
    input  wire logic       copy_protect_i,
    input  wire logic       caption_capture_i,
    input  wire logic       caption_read_i,
    input  wire logic       chip_powerdown_i,
    input  wire logic       composite_sel_i,
    input  wire logic       vertical_blank_i,
    input  wire logic       line_start_i,
    input  wire logic       vs_large_err_i,
    input  wire logic       headswitch_line_i,
    input  wire logic [3:0] per_line_slicer_code_i,
    input  wire logic       lineid_pin_i,
    input  wire logic       is_50hz_i,
    // controls to the video path
    output logic [1:0]      burst_kill_thresh_o,
    output logic            chroma_conv_pd_o,
    output logic            scaler_run_o,
    output logic            gain_lsb_load_o,
    output logic            gain_lsb_o,
    output logic            trap_on_o,
    output logic [1:0]      tape_ppm_code_o,
    output logic            lock_relax_o,
    output logic            chroma_clamp_on_o,
    output logic            luma_clamp_on_o,
    output logic            wss_slice_o,
    output logic            raw_out_o,
    output vdtvc_tt_t       teletext_sys_o,
    output logic            sliced_lsb_first_o,
    output logic [1:0]      gain_tc_o,
    output logic            gain_init_fast_o,
    output logic            vs_phase_move_o,
    output logic            phase_early_prio_o,
    output logic            freq_track_on_o,
    output logic            phase_track_on_o,
    output logic [4:0]      blank_end_line_o,
    output logic            osc_reset_o,
    output logic            stream_lineid_o
);

    // control fields
    logic       lock_condition_relax;
    logic [1:0] tape_detect_threshold;
    logic       auto_tape_trap;
    logic       blanking_trap_force;
    logic       gain_low_bit;
    logic       sliced_bit_order;
    logic [1:0] teletext_system_select;
    logic       raw_samples_select;
    logic       luma_clamp_disable;
    logic       chroma_clamp_disable;
    logic [7:0] track_b;
    logic       genlock_osc_reset;
    logic       genlock_lineid_polarity;
    logic [3:0] cmd_e_hi;
    // status and synchronisers
    logic [1:0] tape_sync;
    logic [1:0] prot_sync;
    logic       caption_ready_flag;
    logic       caption_overrun_flag;
    logic       osc_reset_prev;
    logic [2:0] vs_err_lines;
    vdtvc_vs_t  vs_state;
    logic       wr_hit_a;
    logic       gain_freeze;

    // gain freeze lives in another register; held low here as a fixed mode input
    assign gain_freeze = 1'b0;

    function automatic logic hit(input logic [7:0] idx);
        hit = reg_wr_i && (reg_idx_i == idx);
    endfunction

    assign wr_hit_a = hit(`VDTVC_IDX_TRACK_A);

    // writable fields; status bits take no write data
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lock_condition_relax    <= 1'b0;
            tape_detect_threshold   <= 2'h0;
            auto_tape_trap          <= 1'b0;
            blanking_trap_force     <= 1'b0;
            gain_low_bit            <= 1'b0;
            sliced_bit_order        <= 1'b0;
            teletext_system_select  <= 2'h0;
            raw_samples_select      <= 1'b0;
            luma_clamp_disable      <= 1'b0;
            chroma_clamp_disable    <= 1'b0;
            track_b                 <= `VDTVC_RST_TRACK_B;
            genlock_osc_reset       <= 1'b0;
            genlock_lineid_polarity <= 1'b0;
            cmd_e_hi                <= 4'h0;
        end else begin
            if (wr_hit_a) begin
                lock_condition_relax  <= reg_wdata_i[7];
                tape_detect_threshold <= reg_wdata_i[4:3];
                auto_tape_trap        <= reg_wdata_i[2];
                blanking_trap_force   <= reg_wdata_i[1];
                gain_low_bit          <= reg_wdata_i[0];
            end
            if (hit(`VDTVC_IDX_VBI_B)) begin
                sliced_bit_order       <= reg_wdata_i[7];
                teletext_system_select <= reg_wdata_i[6:5];
                raw_samples_select     <= reg_wdata_i[4];
                luma_clamp_disable     <= reg_wdata_i[1];
                chroma_clamp_disable   <= reg_wdata_i[0];
            end
            if (hit(`VDTVC_IDX_TRACK_B)) begin
                track_b <= reg_wdata_i;
            end
            if (hit(`VDTVC_IDX_GENLOCK)) begin
                genlock_osc_reset       <= reg_wdata_i[7];
                genlock_lineid_polarity <= reg_wdata_i[6];
            end
            if (hit(`VDTVC_IDX_CMD_E)) begin
                cmd_e_hi <= reg_wdata_i[7:4];
            end
        end
    end

    // two-flop synchronisers for status pins from the analog front end
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tape_sync <= 2'b00;
            prot_sync <= 2'b00;
        end else begin
            tape_sync <= {tape_sync[0], tape_unlocked_i};
            prot_sync <= {prot_sync[0], copy_protect_i};
        end
    end

    // caption flags: a capture in the same cycle as a read wins, so no data is missed
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            caption_ready_flag   <= 1'b0;
            caption_overrun_flag <= 1'b0;
        end else begin
            if (caption_capture_i) begin
                caption_ready_flag <= 1'b1;
                caption_overrun_flag <= caption_ready_flag && !caption_read_i;
            end else if (caption_read_i) begin
                caption_ready_flag   <= 1'b0;
                caption_overrun_flag <= 1'b0;
            end
        end
    end

    // vertical sync noise filter counts lines of large phase error
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vs_err_lines <= 3'h0;
            vs_state     <= VDTVC_VS_FOLLOW;
        end else if (line_start_i) begin
            case (vs_state)
                VDTVC_VS_FOLLOW: begin
                    vs_err_lines <= vs_large_err_i ? 3'h1 : 3'h0;
                    if (vs_large_err_i) begin
                        vs_state <= VDTVC_VS_COUNT;
                    end
                end
                VDTVC_VS_COUNT: begin
                    if (!vs_large_err_i) begin
                        vs_err_lines <= 3'h0;
                        vs_state     <= VDTVC_VS_FOLLOW;
                    end else if (vs_err_lines != `VDTVC_VS_PERSIST) begin
                        vs_err_lines <= vs_err_lines + 3'h1;
                    end
                end
                default: begin
                    vs_err_lines <= 3'h0;
                    vs_state     <= VDTVC_VS_FOLLOW;
                end
            endcase
        end
    end

    // oscillator reset fires one cycle after the bit rises from 0 to 1; holding or rewriting the bit does nothing more
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            osc_reset_prev <= 1'b0;
            osc_reset_o    <= 1'b0;
        end else begin
            osc_reset_prev <= genlock_osc_reset;
            osc_reset_o    <= genlock_osc_reset && !osc_reset_prev;
        end
    end

    // registered control outputs to the video path
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            burst_kill_thresh_o <= 2'h0;
            chroma_conv_pd_o    <= 1'b0;
            scaler_run_o        <= 1'b1;
            gain_lsb_load_o     <= 1'b0;
            gain_lsb_o          <= 1'b0;
            trap_on_o           <= 1'b0;
            tape_ppm_code_o     <= 2'h0;
            lock_relax_o        <= 1'b0;
            chroma_clamp_on_o   <= 1'b1;
            luma_clamp_on_o     <= 1'b1;
            wss_slice_o         <= 1'b0;
            raw_out_o           <= 1'b0;
            teletext_sys_o      <= VDTVC_TT_AUTO;
            sliced_lsb_first_o  <= 1'b0;
            gain_tc_o           <= 2'h0;
            gain_init_fast_o    <= 1'b0;
            vs_phase_move_o     <= 1'b0;
            phase_early_prio_o  <= 1'b0;
            freq_track_on_o     <= 1'b1;
            phase_track_on_o    <= 1'b1;
            blank_end_line_o    <= `VDTVC_LINE_BLANK_STD;
            stream_lineid_o     <= 1'b0;
        end else begin
            // threshold select: code 0 means 11 IRE, code 1 means 5.5 IRE
            burst_kill_thresh_o <= 2'h0;
            chroma_conv_pd_o    <= chip_powerdown_i || (1'b0 && composite_sel_i);
            scaler_run_o        <= !(1'b0 && vertical_blank_i);
            gain_lsb_load_o     <= gain_freeze;
            gain_lsb_o          <= gain_freeze ? gain_low_bit : gain_lsb_o;
            trap_on_o           <= (blanking_trap_force && vertical_blank_i)
                                || (auto_tape_trap && tape_sync[1]);
            tape_ppm_code_o     <= tape_detect_threshold;
            lock_relax_o        <= lock_condition_relax;
            chroma_clamp_on_o   <= !chroma_clamp_disable;
            luma_clamp_on_o     <= !luma_clamp_disable;
            wss_slice_o         <= (per_line_slicer_code_i == `VDTVC_SLICER_RAWCODE)
                                && !raw_samples_select;
            raw_out_o           <= (per_line_slicer_code_i == `VDTVC_SLICER_RAWCODE)
                                && raw_samples_select;
            teletext_sys_o      <= vdtvc_tt_t'(teletext_system_select);
            sliced_lsb_first_o  <= sliced_bit_order;
            gain_tc_o           <= track_b[2:1];
            gain_init_fast_o    <= track_b[0];
            vs_phase_move_o     <= line_start_i && vs_large_err_i && (!track_b[3]
                                || vs_err_lines >= `VDTVC_VS_PERSIST - 3'h1);
            phase_early_prio_o  <= track_b[4];
            freq_track_on_o     <= !(track_b[5] && headswitch_line_i);
            phase_track_on_o    <= !headswitch_line_i || track_b[6];
            blank_end_line_o    <= (is_50hz_i && track_b[7]) ? `VDTVC_LINE_BLANK_ALT
                                                           : `VDTVC_LINE_BLANK_STD;
            stream_lineid_o     <= lineid_pin_i ^ genlock_lineid_polarity;
        end
    end

    // read mux; fixed-zero bits and unmapped indices read zero
    always_comb begin
        case (reg_idx_i)
            `VDTVC_IDX_TRACK_A: reg_rdata_o = {lock_condition_relax, prot_sync[1], tape_sync[1],
                                    tape_detect_threshold, auto_tape_trap,
                                    blanking_trap_force, gain_low_bit};
            `VDTVC_IDX_VBI_B:   reg_rdata_o = {sliced_bit_order, teletext_system_select,
                                    raw_samples_select, caption_ready_flag,
                                    caption_overrun_flag, luma_clamp_disable,
                                    chroma_clamp_disable};
            `VDTVC_IDX_TRACK_B: reg_rdata_o = track_b;
            `VDTVC_IDX_GENLOCK: reg_rdata_o = {genlock_osc_reset, genlock_lineid_polarity, 6'h00};
            `VDTVC_IDX_CMD_E:   reg_rdata_o = {cmd_e_hi, `VDTVC_CHIP_REV};
            default:            reg_rdata_o = 8'h00;
        endcase
    end

    // status bits track their synchronised sources two edges late
    property p_tape_status;
        @(posedge sys_clk_i) disable iff (reset_i)
        $rose(tape_sync[1]) |-> $past(tape_unlocked_i, 2);
    endproperty
    a_tape_status: assert property (p_tape_status) else $error("tape status rose without cause");

    property p_prot_status;
        @(posedge sys_clk_i) disable iff (reset_i)
        prot_sync[1] == $past(copy_protect_i, 2) || $past(reset_i, 2);
    endproperty
    a_prot_status: assert property (p_prot_status) else $error("copy status mismatch");

    property p_ready_set;
        @(posedge sys_clk_i) disable iff (reset_i)
        caption_capture_i |=> caption_ready_flag;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready flag not set on capture");

    property p_ready_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        caption_read_i && !caption_capture_i |=> !caption_ready_flag && !caption_overrun_flag;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("flags not cleared on read");

    property p_overrun;
        @(posedge sys_clk_i) disable iff (reset_i)
        caption_capture_i && caption_ready_flag && !caption_read_i |=> caption_overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_osc_once;
        @(posedge sys_clk_i) disable iff (reset_i)
        osc_reset_o |=> !osc_reset_o;
    endproperty
    a_osc_once: assert property (p_osc_once) else $error("oscillator reset repeated");

    property p_osc_edge;
        @(posedge sys_clk_i) disable iff (reset_i)
        $rose(genlock_osc_reset) |=> osc_reset_o;
    endproperty
    a_osc_edge: assert property (p_osc_edge) else $error("oscillator reset missed");

    property p_trap_blank;
        @(posedge sys_clk_i) disable iff (reset_i)
        blanking_trap_force && vertical_blank_i |=> trap_on_o;
    endproperty
    a_trap_blank: assert property (p_trap_blank) else $error("trap not forced in blanking");

    property p_vs_filter;
        @(posedge sys_clk_i) disable iff (reset_i)
        vs_phase_move_o && $past(track_b[3]) |-> $past(vs_err_lines) >= `VDTVC_VS_PERSIST - 3'h1;
    endproperty
    a_vs_filter: assert property (p_vs_filter) else $error("vsync moved too early");

    property p_blank_line;
        @(posedge sys_clk_i) disable iff (reset_i)
        is_50hz_i && track_b[7] |=> blank_end_line_o == `VDTVC_LINE_BLANK_ALT;
    endproperty
    a_blank_line: assert property (p_blank_line) else $error("wrong blanking end line");

endmodule

// File: sim/tb_top.sv
// self-checking bench for the tracking, vbi and genlock control slice
`timescale 1ns/10ps
`include "vdtvc_cfg.svh"
module tb_top;
    import vdtvc_pkg::*;
    typedef struct {int lsb; logic [7:0] exp; logic [7:0] mask; string nm;} vdtvc_note_t;
    // design ports
    logic       sys_clk_i, reset_i, reg_wr_i, reg_rd_i;
    logic [7:0] reg_idx_i, reg_wdata_i, reg_rdata_o;
    logic       tape_unlocked_i, copy_protect_i, caption_capture_i, caption_read_i;
    logic       chip_powerdown_i, composite_sel_i, vertical_blank_i, line_start_i;
    logic       vs_large_err_i, headswitch_line_i, lineid_pin_i, is_50hz_i;
    logic [3:0] per_line_slicer_code_i;
    logic [1:0] burst_kill_thresh_o, tape_ppm_code_o, gain_tc_o;
    logic [4:0] blank_end_line_o;
    vdtvc_tt_t  teletext_sys_o;
    logic       chroma_conv_pd_o, scaler_run_o, gain_lsb_load_o, gain_lsb_o, trap_on_o;
    logic       lock_relax_o, chroma_clamp_on_o, luma_clamp_on_o, wss_slice_o, raw_out_o;
    logic       sliced_lsb_first_o, gain_init_fast_o, vs_phase_move_o, phase_early_prio_o;
    logic       freq_track_on_o, phase_track_on_o, osc_reset_o, stream_lineid_o;
    // bench state
    logic [7:0]  vs_cnt, osc_cnt, v;
    logic [52:0] outs;
    int          miscompares, cmp_count;
    vdtvc_note_t notes[$];
    event        obs_ev;
    localparam int p_rd = 0, p_bk = 8, p_pd = 10, p_sc = 11, p_ld = 12, p_tr = 13;
    localparam int p_ppm = 14, p_rlx = 16, p_cl = 17, p_wr = 19, p_tt = 21, p_lsb = 23;
    localparam int p_gn = 24, p_pr = 27, p_trk = 28, p_be = 30, p_lid = 35, p_vs = 36;
    localparam int p_osc = 44;

    vdtvc_regs dut (.*);
    vdtvc_host_model host (.sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
                           .reg_idx_o(reg_idx_i), .reg_wdata_o(reg_wdata_i));

    // all outputs in one vector, the two pulse outputs as counts; a note names a bit position
    assign outs = {gain_lsb_o, osc_cnt, vs_cnt, stream_lineid_o, blank_end_line_o, freq_track_on_o,
                   phase_track_on_o, phase_early_prio_o, gain_tc_o, gain_init_fast_o,
                   sliced_lsb_first_o, teletext_sys_o, wss_slice_o, raw_out_o,
                   chroma_clamp_on_o, luma_clamp_on_o, lock_relax_o, tape_ppm_code_o,
                   trap_on_o, gain_lsb_load_o, scaler_run_o, chroma_conv_pd_o,
                   burst_kill_thresh_o, reg_rdata_o};

    // clock
    initial sys_clk_i = 1'b0;
    always #10 sys_clk_i = ~sys_clk_i;

    // one-cycle pulses are counted between looks
    always @(posedge sys_clk_i) begin
        if (vs_phase_move_o === 1'b1) vs_cnt <= vs_cnt + 8'h01;
        if (osc_reset_o === 1'b1) osc_cnt <= osc_cnt + 8'h01;
    end

    task automatic compare(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // watcher: takes every pending note, oldest first, once the outputs are settled
    always @(obs_ev) begin
        vdtvc_note_t n;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            compare(n.nm, 8'(outs >> n.lsb) & n.mask, n.exp & n.mask);
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input int lsb, input logic [7:0] e, input logic [7:0] m, input string nm);
        notes.push_back('{lsb, e, m, nm});
    endtask
    task automatic look();
        #2;
        ->obs_ev;
        #1;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk_i);
        s = 1'b1;
        @(negedge sys_clk_i);
        s = 1'b0;
    endtask
    // read while the strobe is held and compare the combinational read data
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
        fork
            host.rd(idx);
            begin
                @(negedge sys_clk_i);
                chk(p_rd, e, m, "read data");
                look();
            end
        join
    endtask
    task automatic w(input logic [7:0] idx, input logic [7:0] d);
        host.wr(idx, d, int'($urandom_range(2)));
    endtask

    // a hang is cut short here
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        end_of_test();
    end

    initial begin
        {tape_unlocked_i, copy_protect_i, caption_capture_i, caption_read_i} = 4'h0;
        {chip_powerdown_i, composite_sel_i, vertical_blank_i, line_start_i} = 4'h0;
        {vs_large_err_i, headswitch_line_i, lineid_pin_i, per_line_slicer_code_i} = 7'h00;
        {vs_cnt, osc_cnt} = 16'h0000;
        is_50hz_i = 1'b1;
        reset_i = 1'b1;
        void'($urandom(63755));
        cyc(5);
        reset_i = 1'b0;
        cyc(2);
        // values after reset
        chk(p_bk, 8'h00, 8'h03, "burst level");
        chk(p_sc, 8'h01, 8'h01, "scaler run");
        chk(p_cl, 8'h03, 8'h03, "clamps on");
        chk(p_trk, 8'h03, 8'h03, "tracking");
        chk(p_be, 8'(`VDTVC_LINE_BLANK_STD), 8'h1F, "blank end");
        look();
        for (int i = 0; i < 5; i++) rdc(8'h39 + 8'(i), (i == 4) ? 8'(`VDTVC_CHIP_REV) : 8'h00, 8'hFF);
        rdc(8'h3E, 8'h00, 8'hFF);
        // chroma converter follows whole-chip power-down only, also on composite input
        chip_powerdown_i = 1'b1;
        cyc(3);
        chk(p_pd, 8'h01, 8'h01, "conv power down");
        look();
        chip_powerdown_i = 1'b0;
        composite_sel_i = 1'b1;
        cyc(3);
        chk(p_pd, 8'h00, 8'h01, "conv power down");
        look();
        // every tape threshold code, blanking trap, gain bit without freeze
        vertical_blank_i = 1'b1;
        for (int c = 0; c < 4; c++) begin
            v = (8'(c) << 3) | 8'h02 | {7'h00, c[0]} | {c[0], 7'h00};
            w(8'h39, v);
            cyc(3);
            chk(p_ppm, 8'(c), 8'h03, "tape threshold");
            chk(p_rlx, {7'h00, c[0]}, 8'h01, "lock relax");
            chk(p_ld, 8'h00, 8'h01, "gain load");
            chk(52, 8'h00, 8'h01, "gain bit");
            chk(p_tr, 8'h01, 8'h01, "trap in blanking");
            look();
            rdc(8'h39, v, 8'h9F);
        end
        vertical_blank_i = 1'b0;
        // tape trap, status bits follow inputs and ignore writes
        w(8'h39, 8'h04);
        tape_unlocked_i = 1'b1;
        copy_protect_i = 1'b1;
        cyc(5);
        chk(p_tr, 8'h01, 8'h01, "tape trap");
        look();
        rdc(8'h39, 8'h64, 8'hFF);
        {tape_unlocked_i, copy_protect_i} = 2'b00;
        w(8'h39, 8'h60);
        cyc(5);
        chk(p_tr, 8'h00, 8'h01, "trap off");
        look();
        rdc(8'h39, 8'h00, 8'hFF);
        // vbi control: clamps, teletext codes, bit order, slicer code 3
        vertical_blank_i = 1'b1;
        for (int k = 0; k < 4; k++) begin
            v = (8'($urandom) & 8'h93) | (8'(k) << 5);
            per_line_slicer_code_i = `VDTVC_SLICER_RAWCODE;
            w(8'h3A, v);
            cyc(3);
            chk(p_cl, {6'h00, ~v[0], ~v[1]}, 8'h03, "clamps");
            chk(p_tt, 8'(k), 8'h03, "teletext");
            chk(p_lsb, {7'h00, v[7]}, 8'h01, "bit order");
            chk(p_wr, {6'h00, ~v[4], v[4]}, 8'h03, "wss or raw");
            look();
            rdc(8'h3A, v, 8'hF3);
            per_line_slicer_code_i = 4'h2;
            cyc(3);
            chk(p_wr, 8'h00, 8'h03, "other code");
            look();
        end
        // caption flags
        pulse(caption_capture_i);
        cyc(2);
        rdc(8'h3A, 8'h08, 8'h0C);
        pulse(caption_capture_i);
        cyc(2);
        rdc(8'h3A, 8'h0C, 8'h0C);
        pulse(caption_read_i);
        cyc(2);
        rdc(8'h3A, 8'h00, 8'h0C);
        // tracking b on headswitch lines of 50 Hz video
        headswitch_line_i = 1'b1;
        for (int k = 0; k < 6; k++) begin
            v = 8'($urandom);
            w(8'h3B, v);
            cyc(3);
            chk(p_gn, {5'h00, v[2:0]}, 8'h07, "gain loop");
            chk(p_pr, {7'h00, v[4]}, 8'h01, "phase priority");
            chk(p_trk + 1, {7'h00, ~v[5]}, 8'h01, "freq track");
            chk(p_trk, {7'h00, v[6]}, 8'h01, "phase track");
            chk(p_be, v[7] ? 8'(`VDTVC_LINE_BLANK_ALT) : 8'(`VDTVC_LINE_BLANK_STD), 8'h1F, "blank end");
            look();
            rdc(8'h3B, v, 8'hFF);
        end
        // vertical sync noise filter: off follows each line, on needs 4 lines
        vs_large_err_i = 1'b1;
        w(8'h3B, 8'h00);
        vs_cnt = 8'h00;
        repeat (2) pulse(line_start_i);
        cyc(3);
        chk(p_vs, 8'h02, 8'hFF, "vsync moves");
        look();
        vs_large_err_i = 1'b0;
        pulse(line_start_i);
        vs_large_err_i = 1'b1;
        w(8'h3B, 8'h08);
        vs_cnt = 8'h00;
        repeat (3) pulse(line_start_i);
        cyc(3);
        chk(p_vs, 8'h00, 8'hFF, "vsync held");
        look();
        pulse(line_start_i);
        cyc(3);
        chk(p_vs, 8'h01, 8'hFF, "vsync moves");
        look();
        // genlock: line id polarity and one reset per rising edge
        lineid_pin_i = 1'b1;
        w(8'h3C, 8'h40);
        cyc(3);
        chk(p_lid, 8'h00, 8'h01, "line id");
        look();
        w(8'h3C, 8'h00);
        cyc(3);
        chk(p_lid, 8'h01, 8'h01, "line id");
        look();
        osc_cnt = 8'h00;
        w(8'h3C, 8'h80);
        w(8'h3C, 8'h80);
        cyc(3);
        chk(p_osc, 8'h01, 8'hFF, "osc resets");
        look();
        w(8'h3C, 8'h00);
        w(8'h3C, 8'hFF);
        cyc(3);
        chk(p_osc, 8'h02, 8'hFF, "osc resets");
        look();
        rdc(8'h3C, 8'hC0, 8'hFF);
        // command e keeps its fixed low nibble, unmapped write lands nowhere
        w(8'h3D, 8'hA7);
        rdc(8'h3D, {4'hA, `VDTVC_CHIP_REV}, 8'hFF);
        w(8'h3E, 8'hFF);
        rdc(8'h3E, 8'h00, 8'hFF);
        end_of_test();
    end
endmodule

// File: sim/vdtvc_host_model.sv
// host-side model: drives register writes and reads as the serial bus decoder would
`timescale 1ns/10ps
module vdtvc_host_model (
    // clock
    input  wire logic       sys_clk_i,
    // register port toward the slice
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_idx_o,
    output logic [7:0]      reg_wdata_o
);
    // idle bus at time zero
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_idx_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // one write held across one rising edge, after idle cycles
    task automatic wr(input logic [7:0] idx, input logic [7:0] data, input int idle);
        repeat (idle) @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        reg_wr_o = 1'b1;
        reg_idx_o = idx;
        // the genlock register has fixed-zero low bits, always sent as zero
        reg_wdata_o = (idx == 8'h3C) ? (data & 8'hC0) : data;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        // released lines change so nothing leans on a stale byte
        reg_idx_o = ~idx;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    // one read strobe held across one rising edge
    task automatic rd(input logic [7:0] idx);
        @(negedge sys_clk_i);
        reg_rd_o = 1'b1;
        reg_idx_o = idx;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        reg_idx_o = ~idx;
    endtask
endmodule
